// file: hw/iopc_pkg.sv
// Package for the I/O port configuration block: register map, reset
// values, per-port capability masks, bus kinds and carrier structs.
// Assumes an 8-bit host bus on the device clock and four ports of up to 8 pins.
package iopc_pkg;

  localparam int IOPC_NPORT = 4;
  localparam int IOPC_PW = 8;

  // Byte offsets from the base of io_register_space; low two bits pick the port
  localparam logic [7:0] IOPC_OFS_DIN = 8'h00;
  localparam logic [7:0] IOPC_OFS_DOUT = 8'h04;
  localparam logic [7:0] IOPC_OFS_MODE = 8'h08;
  localparam logic [7:0] IOPC_OFS_DIR = 8'h0C;
  localparam logic [7:0] IOPC_OFS_DRV = 8'h10;
  localparam logic [7:0] IOPC_OFS_OEN = 8'h14;
  localparam logic [7:0] IOPC_OFS_MMC = 8'h18;

  localparam logic [7:0] IOPC_REG_RST = 8'h00;
  localparam logic [15:0] IOPC_ALAT_RST = 16'h0000;
  localparam logic [7:0] IOPC_MMC_MASK = 8'h80;
  localparam int IOPC_PERIPH_BIT = 7;
  localparam int IOPC_MODE_PORTS = 2;

  // Index 3 is Port D, index 0 is Port A
  localparam logic [3:0][7:0] IOPC_PIN_MASK = {8'h07, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [3:0][7:0] IOPC_OE_MASK = {8'h00, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [3:0][7:0] IOPC_OD_CAP = {8'h00, 8'hFF, 8'hF0, 8'hF0};
  localparam logic [3:0][7:0] IOPC_SLEW_CAP = {8'h07, 8'h00, 8'h0F, 8'h0F};

  typedef enum logic [1:0] {
    IOPC_BUS_MUX = 2'h0,
    IOPC_BUS_PAGE = 2'h1,
    IOPC_BUS_NONMUX = 2'h3,
    IOPC_BUS_EXT = 2'h2
  } iopc_bus_kind_t;

  typedef logic [3:0][7:0] iopc_pins_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic ale;
    logic [15:0] addr;
    logic [7:0] wdata;
  } iopc_bus_t;

  typedef struct packed {
    iopc_pins_t dout;
    logic [1:0][7:0] mode;
    iopc_pins_t dir;
    iopc_pins_t drv;
    logic [7:0] mmc;
  } iopc_regs_t;

  typedef struct packed {
    iopc_regs_t regs;
    logic [15:0] alat;
    iopc_pins_t sync1;
    iopc_pins_t sync2;
    iopc_pins_t input_latch_cell;
    logic [7:0] rdata;
    logic rvalid;
  } iopc_state_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic fast;
  } iopc_cell_t;

endpackage

// file: hw/iopc_pin_cell.sv
// One pin driver stage: registers the wanted drive and level and applies
// open-drain and slew selection. Drives the three pad signals of one pin.
// Assumes the pad wire is resolved outside from out and oe.
module iopc_pin_cell
  import iopc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic drive_i,
  input wire logic value_i,
  input wire logic od_i,
  input wire logic fast_i,
  output logic pad_out_o,
  output logic pad_oe_o,
  output logic slew_fast_o
);

  iopc_cell_t c_reg;
  iopc_cell_t c_next;

  always_comb begin
    c_next = c_reg;
    if (ce_i) begin
      c_next.fast = fast_i;
      if (od_i) begin
        // Open drain only ever pulls low; pull-up is external
        c_next.out = 1'b0;
        c_next.oe = drive_i & ~value_i;
      end else begin
        c_next.out = value_i;
        c_next.oe = drive_i;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign pad_out_o = c_reg.out;
  assign pad_oe_o = c_reg.oe;
  assign slew_fast_o = c_reg.fast;

endmodule

// file: hw/iopc_top.sv
// I/O port configuration for four ports: configuration registers on the
// host bus, address-out and peripheral/data-port muxing, input latch cells.
// Assumes host bus, logic-array terms and straps are on clock_i; pads are not.
module iopc_top
  import iopc_pkg::*;
#(
  parameter logic [7:0] JTAG_PIN_MASK = 8'h0F,
  parameter int JTAG_TDO_BIT = 3
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire iopc_bus_t bus_i,
  input wire iopc_bus_kind_t bus_kind_i,
  input wire logic [2:0][7:0] oe_term_i,
  input wire iopc_pins_t addr_in_sel_i,
  input wire logic periph_select_a_i,
  input wire logic periph_select_b_i,
  input wire logic jtag_en_i,
  input wire logic jtag_tdo_i,
  input wire logic jtag_tdo_oe_i,
  input wire iopc_pins_t pad_in_i,
  output iopc_pins_t pad_out_o,
  output iopc_pins_t pad_oe_o,
  output iopc_pins_t slew_fast_o,
  output iopc_pins_t input_latch_cell_o,
  output logic [7:0] rdata_o,
  output logic rvalid_o
);

  iopc_state_t s_reg;
  iopc_state_t s_next;

  iopc_pins_t pin_drive;
  iopc_pins_t pin_val;
  iopc_pins_t pin_od;
  iopc_pins_t pin_fast;

  logic reg_wr;
  logic reg_rd;
  logic [7:0] grp;
  logic [1:0] prt;
  logic periph_on;
  logic psel_any;
  logic periph_rd;
  logic dataport_on;
  logic [7:0] rd_mux;

  // Address-out nibble map
  // Returns {valid, nibble index}; nibble k is address bits 4k+3..4k.
  function automatic logic [2:0] addr_nib(input iopc_bus_kind_t k, input logic port_b, input logic hi);
    case (k)
      IOPC_BUS_MUX: addr_nib = {1'b1, 1'b0, hi};
      IOPC_BUS_PAGE: addr_nib = {port_b, 1'b1, hi};
      IOPC_BUS_EXT: addr_nib = port_b ? {~hi, 2'b10} : {hi, 2'b01};
      IOPC_BUS_NONMUX: addr_nib = {port_b, 1'b0, hi};
      default: addr_nib = 3'h0;
    endcase
  endfunction

  assign reg_wr = bus_i.sel & bus_i.wr;
  assign reg_rd = bus_i.sel & bus_i.rd & ~bus_i.wr;
  assign grp = {bus_i.addr[7:2], 2'b00};
  assign prt = bus_i.addr[1:0];

  assign periph_on = s_reg.regs.mmc[IOPC_PERIPH_BIT];
  assign psel_any = periph_select_a_i | periph_select_b_i;
  assign periph_rd = periph_on & psel_any & bus_i.rd & ~bus_i.sel;
  assign dataport_on = (bus_kind_i == IOPC_BUS_NONMUX);

  always_comb begin
    case (grp)
      IOPC_OFS_DIN: rd_mux = s_reg.sync2[prt] & IOPC_PIN_MASK[prt];
      IOPC_OFS_DOUT: rd_mux = s_reg.regs.dout[prt];
      IOPC_OFS_MODE: rd_mux = prt < 2'd2 ? s_reg.regs.mode[prt[0]] : IOPC_REG_RST;
      IOPC_OFS_DIR: rd_mux = s_reg.regs.dir[prt];
      IOPC_OFS_DRV: rd_mux = s_reg.regs.drv[prt];
      IOPC_OFS_OEN: rd_mux = pad_oe_o[prt];
      IOPC_OFS_MMC: rd_mux = prt == 2'd0 ? s_reg.regs.mmc : IOPC_REG_RST;
      default: rd_mux = IOPC_REG_RST;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    if (ce_i) begin
      s_next.sync1 = pad_in_i;
      s_next.sync2 = s_reg.sync1;
      s_next.rvalid = 1'b0;
      if (bus_i.ale) begin
        s_next.alat = bus_i.addr;
      end
      // Latch cells picked by addr_in_sel_i close when the strobe drops; others follow sync2
      for (int p = 0; p < IOPC_NPORT; p++) begin
        for (int b = 0; b < IOPC_PW; b++) begin
          if (!(addr_in_sel_i[p][b] && !bus_i.ale)) begin
            s_next.input_latch_cell[p][b] = s_reg.sync2[p][b];
          end
        end
      end
      if (reg_wr) begin
        case (grp)
          IOPC_OFS_DOUT: s_next.regs.dout[prt] = bus_i.wdata;
          // Ports C and D have no mode register
          IOPC_OFS_MODE: begin
            if (prt < 2'd2) begin
              s_next.regs.mode[prt[0]] = bus_i.wdata;
            end
          end
          // Port D keeps three direction bits
          IOPC_OFS_DIR: s_next.regs.dir[prt] = bus_i.wdata & IOPC_PIN_MASK[prt];
          IOPC_OFS_DRV: s_next.regs.drv[prt] = bus_i.wdata & (IOPC_OD_CAP[prt] | IOPC_SLEW_CAP[prt]);
          IOPC_OFS_MMC: begin
            if (prt == 2'd0) begin
              s_next.regs.mmc = bus_i.wdata & IOPC_MMC_MASK;
            end
          end
          default: s_next.regs = s_reg.regs;
        endcase
      end
      if (reg_rd) begin
        s_next.rdata = rd_mux;
        s_next.rvalid = 1'b1;
      end else if (periph_rd) begin
        // Buffered peripheral data comes back through the read port
        s_next.rdata = s_reg.sync2[0];
        s_next.rvalid = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  for (genvar p = 0; p < IOPC_NPORT; p++) begin : g_port
    for (genvar b = 0; b < IOPC_PW; b++) begin : g_pin
      logic io_drive;
      logic io_val;
      logic [2:0] nib;
      logic addr_out;

      // Direction ORed with enable term on A-C
      // Port D takes no enable term; the p < 3 test gives it a constant 0
      assign io_drive = s_reg.regs.dir[p][b] | (p < 3 ? oe_term_i[p % 3][b] & IOPC_OE_MASK[p][b] : 1'b0);
      assign nib = addr_nib(bus_kind_i, p == 1, b >= 4);

      if (p < IOPC_MODE_PORTS) begin : g_mode
        assign addr_out = s_reg.regs.mode[p][b] & nib[2];
      end else begin : g_nomode
        assign addr_out = 1'b0;
      end

      // Output data register feeds software-mode pins
      assign io_val = addr_out ? s_reg.alat[{nib[1:0], 2'b00} + (b % 4)] : s_reg.regs.dout[p][b];

      always_comb begin
        pin_drive[p][b] = io_drive & IOPC_PIN_MASK[p][b];
        pin_val[p][b] = io_val;
        if (p == 0 && dataport_on) begin
          // Port A is the host data bus
          pin_drive[p][b] = s_reg.rvalid;
          pin_val[p][b] = s_reg.rdata[b];
        end else if (p == 0 && periph_on) begin
          // Float unless a peripheral select is active during a host write with sel low
          pin_drive[p][b] = psel_any & bus_i.wr & ~bus_i.sel;
          pin_val[p][b] = bus_i.wdata[b];
        end else if (p == 2 && jtag_en_i && JTAG_PIN_MASK[b]) begin
          // Programming port takes over its Port C pins
          pin_drive[p][b] = (b == JTAG_TDO_BIT) & jtag_tdo_oe_i;
          pin_val[p][b] = jtag_tdo_i;
        end
      end

      // Open drain where the pin allows it
      assign pin_od[p][b] = s_reg.regs.drv[p][b] & IOPC_OD_CAP[p][b];
      // Fast slew where the pin allows it
      assign pin_fast[p][b] = s_reg.regs.drv[p][b] & IOPC_SLEW_CAP[p][b];

      iopc_pin_cell u_cell (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .drive_i(pin_drive[p][b]),
        .value_i(pin_val[p][b]),
        .od_i(pin_od[p][b]),
        .fast_i(pin_fast[p][b]),
        .pad_out_o(pad_out_o[p][b]),
        .pad_oe_o(pad_oe_o[p][b]),
        .slew_fast_o(slew_fast_o[p][b])
      );
    end
  end

  assign input_latch_cell_o = s_reg.input_latch_cell;
  assign rdata_o = s_reg.rdata;
  assign rvalid_o = s_reg.rvalid;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_write_dout;
    ce_i && reg_wr && bus_i.addr[7:0] == IOPC_OFS_DOUT;
  endsequence

  sequence seq_read_dout;
    ce_i && reg_rd && bus_i.addr[7:0] == IOPC_OFS_DOUT;
  endsequence

  a_readback_dout:
    assert property (seq_write_dout ##1 !reg_wr ##1 seq_read_dout
                     |=> s_reg.rvalid && s_reg.rdata == $past(bus_i.wdata, 3))
    else $error("data out register did not read back its write");

  a_portd_dir_bits:
    assert property (s_reg.regs.dir[3][7:3] == 5'h00)
    else $error("port D direction holds bits above two");

  a_mode_addr_value:
    assert property (s_reg.regs.mode[0][0] && bus_kind_i == IOPC_BUS_MUX && !dataport_on && !periph_on
                     |-> pin_val[0][0] == s_reg.alat[0])
    else $error("address out pin A0 not fed from latched A0");

  a_page_mode_map:
    assert property (s_reg.regs.mode[1][5] && bus_kind_i == IOPC_BUS_PAGE |-> pin_val[1][5] == s_reg.alat[13])
    else $error("page mode Port B bit 5 not fed from A13");

  a_io_mode_value:
    assert property (!s_reg.regs.mode[1][4] |-> pin_val[1][4] == s_reg.regs.dout[1][4])
    else $error("software I/O pin not fed from data out register");

  a_portd_dir_only:
    assert property (pin_drive[3][0] == s_reg.regs.dir[3][0])
    else $error("port D drive differs from its direction bit");

  a_oe_term_drive:
    assert property (oe_term_i[2][5] |-> pin_drive[2][5])
    else $error("enable term did not drive Port C pin 5");

  a_periph_float:
    assert property (ce_i && periph_on && !dataport_on && !psel_any |=> !pad_oe_o[0][2])
    else $error("peripheral buffer drove with no select active");

  a_opendrain_low:
    assert property (ce_i && pin_drive[2][2] && pin_od[2][2] && pin_val[2][2] |=> !pad_oe_o[2][2] && !pad_out_o[2][2])
    else $error("open drain pin drove a high level");

  a_dataport_io_off:
    assert property (dataport_on && !s_reg.rvalid |-> !pin_drive[0][3])
    else $error("Port A general I/O active in data port mode");

  a_imc_hold:
    assert property (ce_i && addr_in_sel_i[2][0] && !bus_i.ale |=> s_reg.input_latch_cell[2][0] == $past(s_reg.input_latch_cell[2][0]))
    else $error("closed input latch cell changed");

  a_read_valid:
    assert property (ce_i && reg_rd |=> s_reg.rvalid)
    else $error("register read gave no valid pulse");

  a_rvalid_pulse:
    assert property (ce_i && s_reg.rvalid && !reg_rd && !periph_rd |=> !s_reg.rvalid)
    else $error("read valid stood longer than one cycle");

  a_mode_cd_none:
    assert property (ce_i && reg_wr && grp == IOPC_OFS_MODE && prt >= 2'd2
                     |=> s_reg.regs.mode == $past(s_reg.regs.mode))
    else $error("mode write to Port C or D changed a mode register");

  a_portd_no_drive:
    assert property (pin_drive[3][7:3] == 5'h00)
    else $error("missing Port D pin asked to drive");

  a_dir_drives:
    assert property (s_reg.regs.dir[1][3] |-> pin_drive[1][3])
    else $error("direction bit set but Port B pin 3 not driving");

  a_dir_sole:
    assert property (!s_reg.regs.dir[1][6] && !oe_term_i[1][6] |-> !pin_drive[1][6])
    else $error("Port B pin 6 drove with direction and term both clear");

  a_pushpull_out:
    assert property (ce_i && pin_drive[1][7] && !pin_od[1][7]
                     |=> pad_oe_o[1][7] && pad_out_o[1][7] == $past(pin_val[1][7]))
    else $error("push-pull pin did not drive its value");

  a_slew_fast:
    assert property (ce_i && s_reg.regs.drv[0][1] |=> slew_fast_o[0][1])
    else $error("slew bit set but Port A pin 1 stayed slow");

  a_slew_none_c:
    assert property (slew_fast_o[2] == 8'h00)
    else $error("Port C pin showed fast slew");

  a_drv_unused:
    assert property (s_reg.regs.drv[3][7:3] == 5'h00)
    else $error("unused Port D drive bits were stored");

  a_mmc_unused:
    assert property (s_reg.regs.mmc[6:0] == 7'h00)
    else $error("unused mapping config bits were stored");

  a_periph_drive:
    assert property (ce_i && periph_on && !dataport_on && psel_any && bus_i.wr && !bus_i.sel && !pin_od[0][5]
                     |=> pad_oe_o[0][5] && pad_out_o[0][5] == $past(bus_i.wdata[5]))
    else $error("peripheral buffer did not drive host write data");

  a_jtag_release:
    assert property (ce_i && jtag_en_i && JTAG_PIN_MASK[0] && JTAG_TDO_BIT != 0 |=> !pad_oe_o[2][0])
    else $error("programming pin on Port C 0 still driven");

  a_alat_capture:
    assert property (ce_i && bus_i.ale |=> s_reg.alat == $past(bus_i.addr))
    else $error("address strobe did not capture the address");

endmodule

// file: verification/iopc_host_model.sv
// Host model: plain register and peripheral cycles on the device clock.
// Assumes the block samples on the rising edge; drives on the falling edge.
module iopc_host_model
  import iopc_pkg::*;
(
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output iopc_bus_t bus_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial bus_o = '0;

  task automatic cycle(input logic s, input logic w, input logic [15:0] a, input logic [7:0] d, input int n);
    @(negedge clock_i);
    bus_o.sel = s;
    bus_o.wr = w;
    bus_o.rd = ~w;
    bus_o.addr = a;
    bus_o.wdata = d;
    repeat (n) @(negedge clock_i);
    bus_o.sel = 1'b0;
    bus_o.wr = 1'b0;
    bus_o.rd = 1'b0;
    // Released address and data lines flip so stale data is never mistaken for held data
    bus_o.addr = ~a;
    bus_o.wdata = ~d;
  endtask

  task automatic strobe(input logic [15:0] a);
    @(negedge clock_i);
    bus_o.ale = 1'b1;
    bus_o.addr = a;
    @(negedge clock_i);
    bus_o.ale = 1'b0;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge clock_i);
    bus_o.sel = 1'b1;
    bus_o.rd = 1'b1;
    bus_o.addr = {8'h00, a};
    for (int i = 0; i < 4 && ok == 1'b0; i++) begin
      @(negedge clock_i);
      bus_o.sel = 1'b0;
      bus_o.rd = 1'b0;
      if (rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = rdata_i;
      end
    end
  endtask
endmodule

// file: verification/tb.sv
// Self-checking bench for the I/O port configuration block.
// Assumes the host model owns the bus; pads are observed, not resolved.
module tb
  import iopc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_a = 1'b0;
  logic jtag_en = 1'b0;
  logic tdo_oe = 1'b0;
  iopc_bus_t bus;
  iopc_bus_kind_t kind = IOPC_BUS_MUX;
  logic [2:0][7:0] oe_term = '0;
  iopc_pins_t pad_in = '0;
  iopc_pins_t addr_sel = '0;
  iopc_pins_t pad_out;
  iopc_pins_t pad_oe;
  iopc_pins_t slew;
  iopc_pins_t ilc;
  logic [7:0] rdata;
  logic rvalid;
  int err_count = 0;
  int checked = 0;
  // Offset, written value, read-back value
  logic [23:0] rows [8] = '{24'h08FFFF, 24'h0A3C00, 24'h0FFF07, 24'h13FF07,
                            24'h18FF80, 24'h1C5500, 24'h0D8181, 24'h04A5A5};
  logic [15:0] kexp [4] = '{16'hA5A5, 16'h3C00, 16'h0CA0, 16'hA500};

  initial forever #50 clock_i = ~clock_i;

  iopc_host_model host (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .bus_o(bus));

  iopc_top dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .bus_i(bus), .bus_kind_i(kind),
    .oe_term_i(oe_term), .addr_in_sel_i(addr_sel), .periph_select_a_i(psel_a), .periph_select_b_i(1'b0),
    .jtag_en_i(jtag_en), .jtag_tdo_i(1'b0), .jtag_tdo_oe_i(tdo_oe), .pad_in_i(pad_in),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .slew_fast_o(slew), .input_latch_cell_o(ilc), .rdata_o(rdata),
    .rvalid_o(rvalid));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.cycle(1'b1, 1'b1, {8'h00, a}, d, 1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.read(a, d, ok);
    check("read handshake", {31'd0, ok}, 32'd1);
    check("read data", {24'd0, d}, {24'd0, exp});
  endtask

  task automatic settle();
    repeat (3) @(negedge clock_i);
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clock_i);
    rst_i = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd_chk(rows[i][23:16], rows[i][7:0]);
    end
    // Reset in mid-run must clear everything again
    @(negedge clock_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    check("oe after reset", pad_oe, 32'h0);
    rd_chk(8'h0D, 8'h00);
    rd_chk(8'h18, 8'h00);
    wr(8'h0C, 8'h5A);
    wr(8'h0F, 8'h05);
    oe_term[1] = 8'h81;
    pad_in[1] = 8'h96;
    settle();
    check("direction and terms", pad_oe, 32'h0500815A);
    rd_chk(8'h15, 8'h81);
    rd_chk(8'h17, 8'h05);
    rd_chk(8'h01, 8'h96);
    wr(8'h0E, 8'hFF);
    wr(8'h06, 8'h0F);
    settle();
    check("data out pins", pad_out[2], 32'h0F);
    jtag_en = 1'b1;
    tdo_oe = 1'b1;
    settle();
    check("programming pins", pad_oe[2], 32'hF8);
    jtag_en = 1'b0;
    wr(8'h12, 8'hFF);
    wr(8'h10, 8'h0F);
    wr(8'h13, 8'h07);
    settle();
    check("open drain oe", pad_oe[2], 32'hF0);
    check("open drain out", pad_out[2], 32'h00);
    check("slew", slew, 32'h0700000F);
    wr(8'h08, 8'hFF);
    wr(8'h09, 8'hFF);
    wr(8'h0C, 8'hFF);
    wr(8'h0D, 8'hFF);
    host.strobe(16'h3CA5);
    for (int k = 0; k < 4; k++) begin
      kind = iopc_bus_kind_t'(k[1:0]);
      settle();
      check("address out b", pad_out[1], {24'd0, kexp[k][15:8]});
      if (k < 3) check("address out a", pad_out[0], {24'd0, kexp[k][7:0]});
    end
    kind = IOPC_BUS_MUX;
    wr(8'h0C, 8'h00);
    wr(8'h18, 8'h80);
    psel_a = 1'b1;
    fork
      host.cycle(1'b0, 1'b1, 16'h0000, 8'h3C, 4);
      begin
        repeat (3) @(posedge clock_i);
        #1;
        check("periph drive oe", pad_oe[0], 32'hFF);
        check("periph drive out", pad_out[0], 32'h3C);
      end
    join
    psel_a = 1'b0;
    fork
      host.cycle(1'b0, 1'b1, 16'h0000, 8'h3C, 4);
      begin
        repeat (3) @(posedge clock_i);
        #1;
        check("periph float", pad_oe[0], 32'h00);
      end
    join
    // Address pin holds between strobes
    pad_in[2] = 8'h01;
    addr_sel[2] = 8'h01;
    settle();
    check("latch cell shut", ilc[2], 32'h00);
    host.strobe(16'h3CA5);
    pad_in[2] = 8'h00;
    settle();
    check("latch cell held", ilc[2], 32'h01);
    tally_and_finish();
  end
endmodule
